// File: design/deep_sleep_gate.sv
/*
 Deep-sleep clock gating register with APB slave, effective clock enables
 and bus-fault answers for accesses to unclocked units. Assumes one clock,
 MCLK, and synchronous active-high reset; unit selects come from the
 system bus decoder on the same clock.
*/
`timescale 1ns/100ps
// Function
// - Bit 26 enables analog comparator two clock, read/write, reset zero.
// - Bit 25 enables analog comparator one clock, read/write, reset zero.
// - An access to a unit whose clock is off is answered with a bus fault.
// - Bits 31:27 are reserved, read as zero and ignore writes.
// - Bits 19:16 enable timers three to zero, read/write, reset zero.
// - Bit 12 enables the two-wire controller; bits 15:13 and 11:5 read zero.
// - Bit 4 enables the sync serial port, bits 1:0 the UARTs; bits 3:2 zero.
// - These enables apply only in deep-sleep with automatic gating set.
module deep_sleep_gate #(
    parameter int UNITS = dsgate_pkg::UNIT_COUNT
) (
    input wire logic MCLK, // System clock
    input wire logic SYS_RST, // Synchronous reset, active high
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB enable
    input wire logic PWRITE, // APB direction
    input wire logic [11:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error
    input wire logic DEEP_SLEEP, // Chip is in deep-sleep
    input wire logic [UNITS-1:0] RUN_GATE, // Run-mode enables, packed order
    input wire logic [UNITS-1:0] UNIT_SELECT, // Unit access strobes
    output logic [UNITS-1:0] UNIT_CLOCK_ON, // Effective unit clock enables
    output logic UNIT_BUS_FAULT, // Fault answer to a unit access
    output logic IRQ // Interrupt, level
);
    if (UNITS != dsgate_pkg::UNIT_COUNT) begin : g_bad
        $error("UNITS must match the register layout");
    end

    dsgate_pkg::apb_req_t req;
    logic [31:0] gate_ff;
    logic auto_gate_ff;
    logic [3:0] status_ff;
    logic [3:0] mask_ff;
    logic [3:0] evt;
    logic [UNITS-1:0] ds_gate;
    logic [UNITS-1:0] nxt_clock_on;
    logic [UNITS-1:0] fault_vec;
    logic acc;
    logic wr;
    logic [31:0] nxt_rdata;
    logic nxt_err;

    assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA};
    // Slave answers in the setup cycle, so every access phase sees pready high
    assign acc = req.sel & ~req.enable;
    assign wr = req.sel & req.enable & req.write & PREADY;

    // Unit order: comparator_two_clock_enable..0, timer3..0, two-wire, sync serial, serial_port_one_clock_enable, serial_port_zero_clock_enable
    assign ds_gate = {gate_ff[dsgate_pkg::COMP_ZERO_POS +: 3],
                      gate_ff[dsgate_pkg::TIMER_ZERO_POS +: 4],
                      gate_ff[dsgate_pkg::TWO_WIRE_POS],
                      gate_ff[dsgate_pkg::SYNC_SERIAL_POS],
                      gate_ff[dsgate_pkg::SERIAL_ONE_POS],
                      gate_ff[dsgate_pkg::SERIAL_ZERO_POS]};
    assign nxt_clock_on = (DEEP_SLEEP && auto_gate_ff) ? ds_gate : RUN_GATE;

    unit_fault_check #(
        .UNITS(UNITS)
    ) u_check (
        .unit_clock_on(UNIT_CLOCK_ON),
        .unit_select(UNIT_SELECT),
        .unit_fault(fault_vec)
    );

    // Events: unit fault, gate write, deep-sleep entry, deep-sleep exit
    logic sleep_q_ff;
    assign evt = {|fault_vec, wr && req.addr == dsgate_pkg::GATE_OFFSET,
                  DEEP_SLEEP & ~sleep_q_ff, ~DEEP_SLEEP & sleep_q_ff};

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            gate_ff <= dsgate_pkg::GATE_RESET;
        end else if (wr && req.addr == dsgate_pkg::GATE_OFFSET) begin
            // Reserved bits never store, so they always read zero
            gate_ff <= req.wdata & dsgate_pkg::GATE_WRITABLE;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            auto_gate_ff <= 1'b0;
            mask_ff <= dsgate_pkg::EVT_RESET;
        end else if (wr && req.addr == dsgate_pkg::MODE_OFFSET) begin
            auto_gate_ff <= req.wdata[dsgate_pkg::AUTO_GATE_POS];
        end else if (wr && req.addr == dsgate_pkg::MASK_OFFSET) begin
            mask_ff <= req.wdata[3:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            status_ff <= dsgate_pkg::EVT_RESET;
            sleep_q_ff <= 1'b0;
        end else begin
            sleep_q_ff <= DEEP_SLEEP;
            // A new event wins over a write-one clear in the same cycle
            if (wr && req.addr == dsgate_pkg::STATUS_OFFSET) begin
                status_ff <= (status_ff & ~req.wdata[3:0]) | evt;
            end else begin
                status_ff <= status_ff | evt;
            end
        end
    end

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_err = 1'b0;
        case (req.addr)
            dsgate_pkg::GATE_OFFSET: nxt_rdata = gate_ff;
            dsgate_pkg::MODE_OFFSET: nxt_rdata = {30'h0000_0000, DEEP_SLEEP, auto_gate_ff};
            dsgate_pkg::STATUS_OFFSET: nxt_rdata = {28'h000_0000, status_ff};
            dsgate_pkg::MASK_OFFSET: nxt_rdata = {28'h000_0000, mask_ff};
            default: nxt_err = 1'b1;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= acc;
            PRDATA <= acc ? nxt_rdata : 32'h0000_0000;
            PSLVERR <= acc & nxt_err;
        end
    end

    always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
            UNIT_CLOCK_ON <= '0;
            UNIT_BUS_FAULT <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            UNIT_CLOCK_ON <= nxt_clock_on;
            UNIT_BUS_FAULT <= |fault_vec;
            IRQ <= |((status_ff | evt) & mask_ff);
        end
    end

    AST_COMP_TWO: assert property (@(posedge MCLK) disable iff (SYS_RST)
        DEEP_SLEEP && auto_gate_ff |=> UNIT_CLOCK_ON[10] == $past(gate_ff[26]))
        else $error("comparator two enable wrong in deep-sleep");
    AST_COMP_ONE: assert property (@(posedge MCLK) disable iff (SYS_RST)
        DEEP_SLEEP && auto_gate_ff |=> UNIT_CLOCK_ON[9] == $past(gate_ff[25]))
        else $error("comparator one enable wrong in deep-sleep");
    AST_FAULT: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (UNIT_SELECT & ~UNIT_CLOCK_ON) != '0 |=> UNIT_BUS_FAULT)
        else $error("no bus fault for unclocked unit");
    AST_NO_FAULT: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (UNIT_SELECT & ~UNIT_CLOCK_ON) == '0 |=> !UNIT_BUS_FAULT)
        else $error("spurious bus fault");
    AST_RESERVED: assert property (@(posedge MCLK) disable iff (SYS_RST)
        gate_ff[31:27] == 5'h00)
        else $error("reserved bits not zero");
    AST_COMP_ZERO: assert property (@(posedge MCLK) disable iff (SYS_RST)
        wr && req.addr == dsgate_pkg::GATE_OFFSET |=> gate_ff[24] == $past(req.wdata[24]))
        else $error("comparator zero bit not stored");
    AST_TIMERS: assert property (@(posedge MCLK) disable iff (SYS_RST)
        wr && req.addr == dsgate_pkg::GATE_OFFSET |=> gate_ff[19:16] == $past(req.wdata[19:16]))
        else $error("timer bits not stored");
    AST_GAPS: assert property (@(posedge MCLK) disable iff (SYS_RST)
        gate_ff[15:13] == 3'h0 && gate_ff[11:5] == 7'h00 && gate_ff[3:2] == 2'h0)
        else $error("reserved gap bits not zero");
    AST_RUN_MODE: assert property (@(posedge MCLK) disable iff (SYS_RST)
        !(DEEP_SLEEP && auto_gate_ff) |=> UNIT_CLOCK_ON == $past(RUN_GATE))
        else $error("run-mode enables not applied");

    // Every writable bit takes the written value on a gate write
    AST_COMP_TWO_STORE: assert property (@(posedge MCLK) disable iff (SYS_RST)
        wr && req.addr == dsgate_pkg::GATE_OFFSET |=> gate_ff[26] == $past(req.wdata[26]))
        else $error("comparator two bit not stored");
    AST_COMP_ONE_STORE: assert property (@(posedge MCLK) disable iff (SYS_RST)
        wr && req.addr == dsgate_pkg::GATE_OFFSET |=> gate_ff[25] == $past(req.wdata[25]))
        else $error("comparator one bit not stored");
    AST_TWO_WIRE_STORE: assert property (@(posedge MCLK) disable iff (SYS_RST)
        wr && req.addr == dsgate_pkg::GATE_OFFSET |=> gate_ff[12] == $past(req.wdata[12]))
        else $error("two-wire bit not stored");
    AST_SERIAL_STORE: assert property (@(posedge MCLK) disable iff (SYS_RST)
        wr && req.addr == dsgate_pkg::GATE_OFFSET |=> gate_ff[4] == $past(req.wdata[4]) &&
        gate_ff[1:0] == $past(req.wdata[1:0]))
        else $error("serial bits not stored");

    // The remaining enables reach the units only through the deep-sleep path
    AST_COMP_ZERO_APPLY: assert property (@(posedge MCLK) disable iff (SYS_RST)
        DEEP_SLEEP && auto_gate_ff |=> UNIT_CLOCK_ON[8] == $past(gate_ff[24]))
        else $error("comparator zero enable wrong in deep-sleep");
    AST_TIMER_APPLY: assert property (@(posedge MCLK) disable iff (SYS_RST)
        DEEP_SLEEP && auto_gate_ff |=> UNIT_CLOCK_ON[7:4] == $past(gate_ff[19:16]))
        else $error("timer enables wrong in deep-sleep");
    AST_TWO_WIRE_APPLY: assert property (@(posedge MCLK) disable iff (SYS_RST)
        DEEP_SLEEP && auto_gate_ff |=> UNIT_CLOCK_ON[3] == $past(gate_ff[12]))
        else $error("two-wire enable wrong in deep-sleep");
    AST_SERIAL_APPLY: assert property (@(posedge MCLK) disable iff (SYS_RST)
        DEEP_SLEEP && auto_gate_ff |=> UNIT_CLOCK_ON[2] == $past(gate_ff[4]) &&
        UNIT_CLOCK_ON[1:0] == $past(gate_ff[1:0]))
        else $error("serial enables wrong in deep-sleep");

    // Reserved bits must read zero on the bus too, not only in storage
    AST_RESERVED_READ: assert property (@(posedge MCLK) disable iff (SYS_RST)
        acc && req.addr == dsgate_pkg::GATE_OFFSET |=> PRDATA[31:27] == 5'h00)
        else $error("reserved bits read nonzero");
    AST_GAP_READ: assert property (@(posedge MCLK) disable iff (SYS_RST)
        acc && req.addr == dsgate_pkg::GATE_OFFSET |=>
        PRDATA[15:13] == 3'h0 && PRDATA[11:5] == 7'h00)
        else $error("gap bits read nonzero");

    // Held reset loads the gate register with its reset value
    AST_GATE_RESET: assert property (@(posedge MCLK)
        SYS_RST |=> gate_ff == dsgate_pkg::GATE_RESET)
        else $error("gate register not cleared by reset");

    COV_GATE_WRITE: cover property (@(posedge MCLK) wr && req.addr == dsgate_pkg::GATE_OFFSET);
    COV_DEEP_APPLY: cover property (@(posedge MCLK) DEEP_SLEEP && auto_gate_ff);
    COV_FAULT: cover property (@(posedge MCLK) UNIT_BUS_FAULT);
    COV_IRQ: cover property (@(posedge MCLK) IRQ);
    COV_UNMAPPED: cover property (@(posedge MCLK) PSLVERR);
endmodule : deep_sleep_gate

// File: design/dsgate_pkg.sv
/*
 Package for the deep-sleep clock gating register block: offsets, field
 positions, reset values and the carrier structs. Assumes an APB bus with
 32-bit data and one clock domain.
*/
package dsgate_pkg;
    localparam logic [11:0] GATE_OFFSET = 12'h0124;
    localparam logic [11:0] MODE_OFFSET = 12'h0128;
    localparam logic [11:0] STATUS_OFFSET = 12'h012C;
    localparam logic [11:0] MASK_OFFSET = 12'h0130;
    localparam logic [31:0] GATE_RESET = 32'h0000_0000;
    localparam logic [31:0] GATE_WRITABLE = 32'h070F_1013;
    localparam int COMP_ZERO_POS = 24;
    localparam int TIMER_ZERO_POS = 16;
    localparam int TWO_WIRE_POS = 12;
    localparam int SYNC_SERIAL_POS = 4;
    localparam int SERIAL_ONE_POS = 1;
    localparam int SERIAL_ZERO_POS = 0;
    localparam int AUTO_GATE_POS = 0;
    localparam int DEEP_SLEEP_POS = 1;
    localparam int UNIT_COUNT = 11;
    localparam logic [3:0] EVT_RESET = 4'h0;

    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic ready;
        logic slverr;
    } apb_rsp_t;
endpackage : dsgate_pkg

// File: design/unit_fault_check.sv
/*
 Per-unit access check: flags an access to a unit whose clock is off.
 Assumes enables and selects are synchronous to MCLK.
*/
`timescale 1ns/100ps
module unit_fault_check #(
    parameter int UNITS = 11
) (
    input wire logic [UNITS-1:0] unit_clock_on, // Effective clock enables
    input wire logic [UNITS-1:0] unit_select, // Unit access requests
    output logic [UNITS-1:0] unit_fault // Access to an unclocked unit
);
    for (genvar i = 0; i < UNITS; i++) begin : g_unit
        assign unit_fault[i] = unit_select[i] & ~unit_clock_on[i];
    end
endmodule : unit_fault_check

// File: bench/tb_deep_sleep_gate.sv
/*
 Self-checking bench for deep_sleep_gate: APB master tasks, a small model of
 the gating register, unit enables, bus faults and the event interrupt.
 Assumes the package offsets and a zero-wait-state APB slave.
*/
`timescale 1ns/100ps
module tb_deep_sleep_gate;
    localparam logic [11:0] GATE_A = dsgate_pkg::GATE_OFFSET;
    localparam logic [11:0] MODE_A = dsgate_pkg::MODE_OFFSET;
    localparam logic [11:0] STAT_A = dsgate_pkg::STATUS_OFFSET;
    localparam logic [11:0] MASK_A = dsgate_pkg::MASK_OFFSET;
    localparam logic [31:0] RW_BITS = 32'h070F_1013;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic deep_sleep = 1'b0;
    logic [10:0] run_gate = 11'h000;
    logic [10:0] unit_select = 11'h000;
    logic [31:0] prdata;
    logic pready, pslverr, unit_bus_fault, irq;
    logic [10:0] unit_clock_on;
    logic [10:0] exp_u;
    logic [31:0] rd;
    logic err;
    int fails = 0;
    int comparisons = 0;
    int gate_m = 0;

    always #5 mclk = ~mclk;

    deep_sleep_gate dut (.MCLK(mclk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .DEEP_SLEEP(deep_sleep), .RUN_GATE(run_gate),
        .UNIT_SELECT(unit_select), .UNIT_CLOCK_ON(unit_clock_on),
        .UNIT_BUS_FAULT(unit_bus_fault), .IRQ(irq));

    // Unit order: comparator_two_clock_enable..comparator_zero_clock_enable, timer3..timer_zero_clock_enable, two-wire, sync serial, serial_port_one_clock_enable, serial_port_zero_clock_enable
    function automatic logic [10:0] units(input logic [31:0] g);
        return {g[26:24], g[19:16], g[12], g[4], g[1:0]};
    endfunction : units

    task end_sim;
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            end_sim();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    // Reads the sticky events, compares, then clears what was read
    task ev(input logic [31:0] exp);
        apb(1'b0, STAT_A, 32'h0000_0000);
        chk(rd, exp);
        apb(1'b1, STAT_A, rd);
    endtask : ev

    initial begin
        void'($urandom(32'h6840));
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        apb(1'b0, GATE_A, 32'h0000_0000);
        chk(rd, dsgate_pkg::GATE_RESET);
        apb(1'b1, MODE_A, 32'h0000_0001);
        repeat (6) begin
            gate_m = $urandom;
            apb(1'b1, GATE_A, gate_m);
            apb(1'b0, GATE_A, 32'h0000_0000);
            chk(rd, gate_m & RW_BITS);
            run_gate <= 11'($urandom);
            deep_sleep <= 1'b0;
            repeat (3) @(posedge mclk);
            chk(unit_clock_on, run_gate);
            deep_sleep <= 1'b1;
            repeat (3) @(posedge mclk);
            chk(unit_clock_on, units(gate_m));
        end
        apb(1'b0, MODE_A, 32'h0000_0000);
        chk(rd, 32'h0000_0003);
        exp_u = units(gate_m);
        for (int i = 0; i < 11; i++) begin
            unit_select <= 11'(1 << i);
            @(posedge mclk);
            unit_select <= 11'h000;
            @(posedge mclk);
            chk(unit_bus_fault, !exp_u[i]);
        end
        apb(1'b1, MODE_A, 32'h0000_0000);
        repeat (3) @(posedge mclk);
        chk(unit_clock_on, run_gate);
        run_gate <= 11'h000;
        apb(1'b1, 12'h200, 32'hFFFF_FFFF);
        chk(err, 1'b1);
        apb(1'b0, 12'h200, 32'h0000_0000);
        chk(err, 1'b1);
        chk(rd, 32'h0000_0000);
        apb(1'b1, STAT_A, 32'h0000_000F);
        apb(1'b1, MASK_A, 32'h0000_0008);
        ev(32'h0000_0000);
        unit_select <= 11'($urandom) | 11'h001;
        @(posedge mclk);
        unit_select <= 11'h000;
        repeat (3) @(posedge mclk);
        chk(irq, 1'b1);
        ev(32'h0000_0008);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        deep_sleep <= 1'b0;
        repeat (2) @(posedge mclk);
        deep_sleep <= 1'b1;
        ev(32'h0000_0003);
        apb(1'b1, GATE_A, 32'h0000_0000);
        ev(32'h0000_0004);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        apb(1'b1, GATE_A, 32'h0000_0000);
        apb(1'b0, GATE_A, 32'h0000_0000);
        chk(rd, dsgate_pkg::GATE_RESET);
        end_sim();
    end
endmodule : tb_deep_sleep_gate
